// ### irq_event_consts.svh
`ifndef IRQ_EVENT_CONSTS_SVH
`define IRQ_EVENT_CONSTS_SVH
`define OFS_IO_CONTROL_ZERO   8'h15
`define OFS_IO_EVENT_STATUS   8'h16
`define OFS_IO_CONTROL_ONE    8'h16
`define OFS_STATUS_WORD       8'h18
`define OFS_PENDING           8'h19
`define OFS_VECTOR            8'h1a
`define VECTOR_BASE           16'h2000
`define PSW_GLOBAL_BIT        9
`define PSW_STICKY_BIT        8
`define PSW_CARRY_BIT         11
`define PSW_TRAP_BIT          12
`define PSW_OVF_BIT           13
`define PSW_NEG_BIT           14
`define PSW_ZERO_BIT          15
`define PSW_WRITE_MASK        16'hfbff
`define CTL_RESET             8'h00
`define PSW_RESET             16'h0000
`define SRC_OVERFLOW          3'h0
`define SRC_CONVERT           3'h1
`define SRC_FAST_DATA         3'h2
`define SRC_FAST_OUT          3'h3
`define SRC_FAST_LINE0        3'h4
`define SRC_EXTERNAL          3'h7
`endif

// ### irq_event_pkg.sv
package irq_event_pkg;
   typedef struct packed {
      logic       fast_cond_full;
      logic       fast_out5_en;
      logic       serial_tx_sel;
      logic       fast_out4_en;
      logic       t2_ovf_int_en;
      logic       t1_ovf_int_en;
      logic       ext_from_analog;
      logic       pwm_sel;
   } io_control_one_t;
   typedef struct packed {
      logic       t2_clk_fast1;
      logic       fast3_en;
      logic       t2_rst_fast0;
      logic       fast2_en;
      logic       t2_ext_rst_en;
      logic       fast1_en;
      logic       t2_reset_write;
      logic       fast0_en;
   } io_control_zero_t;
   typedef struct packed {
      logic       valid;
      logic [2:0] level;
      logic [15:0] address;
   } vector_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACK  = 3'b010,
      ST_DONE = 3'b100
   } bus_state_t;
endpackage : irq_event_pkg

// ### irq_priority_pick.sv
`timescale 1ns/1ps
`include "irq_event_consts.svh"
module irq_priority_pick
   import irq_event_pkg::*;
#(
   parameter int SOURCES = 8
)(
   input  wire logic [SOURCES-1:0] request_i,
   output vector_t                 pick_o
);
   if (SOURCES != 8)
   begin : g_bad_sources
      $error("Source count must be eight");
   end
   // Scan upward so the highest level wins
   always_comb
   begin
      pick_o = '0;
      for (int i = 0; i < SOURCES; i++)
      begin
         if (request_i[i])
         begin
            pick_o.valid   = 1'b1;
            pick_o.level   = 3'(i);
            pick_o.address = `VECTOR_BASE + 16'(2 * i);
         end
      end
   end
endmodule : irq_priority_pick

// ### irq_event_ctrl.sv
`timescale 1ns/1ps
`include "irq_event_consts.svh"
module irq_event_ctrl
   import irq_event_pkg::*;
#(
   parameter int SOURCES = 8
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [3:0]  soft_timer_expired_i,
   input  wire logic        timer1_overflow_i,
   input  wire logic        timer2_overflow_i,
   input  wire logic        fifo_full_i,
   input  wire logic        holding_loaded_i,
   input  wire logic        convert_done_i,
   input  wire logic        fast_out_event_i,
   input  wire logic        fast_line0_event_i,
   input  wire logic        software_timer_event_i,
   input  wire logic        serial_event_i,
   input  wire logic        external_interrupt_pin_i,
   input  wire logic        analog_channel_seven_i,
   input  wire logic [4:0]  alu_flags_i,
   input  wire logic        alu_flags_we_i,
   input  wire logic        sticky_i,
   input  wire logic        sticky_we_i,
   input  wire logic        vector_take_i,
   output logic             irq_request_o,
   output logic [15:0]      vector_address_o,
   output logic [2:0]       vector_level_o,
   output logic [3:0]       fast_input_enable_o,
   output logic [1:0]       fast_output_enable_o,
   output logic             pwm_to_port2_bit5_o,
   output logic             serial_to_port2_bit0_o,
   output logic             timer2_reset_o,
   output logic             timer2_ext_reset_en_o,
   output logic             timer2_reset_from_fast0_o,
   output logic             timer2_clock_from_fast1_o,
   output logic             ext_from_analog_o
);
   // -----------------------------------------------
   // State
   // -----------------------------------------------
   io_control_zero_t ctl0;
   io_control_one_t  ctl1;
   logic [15:0]      processor_status_word;
   logic [7:0]       pending;
   logic [7:0]       event_status;
   logic [7:0]       next_raise;
   logic [7:0]       eligible;
   logic             ext_level;
   logic             ext_prev;
   vector_t          pick;
   bus_state_t       state;
   logic             wr_hit;
   logic             rd_hit;

   if (SOURCES != 8)
   begin : g_bad_sources
      $error("Source count must be eight");
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[5:0]);
   endfunction : hit

   // -----------------------------------------------
   // Wishbone slave
   // -----------------------------------------------
   // Register index times four is the byte address
   // Writes land at the ack edge, so an abandoned write changes nothing
   assign wr_hit = cyc_i && stb_i && we_i && sel_i[0] && ack_o && (state == ST_ACK);
   assign rd_hit = cyc_i && stb_i && !we_i && (state == ST_IDLE);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= ST_IDLE;
      else
         case (state)
            ST_IDLE: if (cyc_i && stb_i) state <= ST_ACK;
            ST_ACK:  state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= cyc_i && stb_i && (state == ST_IDLE);
   end

   // Reads of control zero return zero; control one shares its address with the event status, which is read instead
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= '0;
      else if (rd_hit)
      begin
         if (hit(adr_i, `OFS_IO_EVENT_STATUS))
            dat_o <= {24'h0, event_status};
         else if (hit(adr_i, `OFS_STATUS_WORD))
            dat_o <= {16'h0, processor_status_word};
         else if (hit(adr_i, `OFS_PENDING))
            dat_o <= {24'h0, pending};
         else if (hit(adr_i, `OFS_VECTOR))
            dat_o <= {12'h0, pick.valid, pick.level, pick.address};
         else
            dat_o <= '0;
      end
   end

   // -----------------------------------------------
   // Control registers
   // -----------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctl0 <= `CTL_RESET;
      else if (wr_hit && hit(adr_i, `OFS_IO_CONTROL_ZERO))
         ctl0 <= dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctl1 <= `CTL_RESET;
      else if (wr_hit && hit(adr_i, `OFS_IO_CONTROL_ONE))
         ctl1 <= dat_i[7:0];
   end

   // Reset pulse follows every control zero write with bit 1 set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         timer2_reset_o <= 1'b0;
      else
         timer2_reset_o <= wr_hit && hit(adr_i, `OFS_IO_CONTROL_ZERO) && dat_i[1];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fast_input_enable_o       <= '0;
         fast_output_enable_o      <= '0;
         pwm_to_port2_bit5_o       <= 1'b0;
         serial_to_port2_bit0_o    <= 1'b0;
         timer2_ext_reset_en_o     <= 1'b0;
         timer2_reset_from_fast0_o <= 1'b0;
         timer2_clock_from_fast1_o <= 1'b0;
         ext_from_analog_o         <= 1'b0;
      end
      else
      begin
         fast_input_enable_o       <= {ctl0.fast3_en, ctl0.fast2_en, ctl0.fast1_en, ctl0.fast0_en};
         fast_output_enable_o      <= {ctl1.fast_out5_en, ctl1.fast_out4_en};
         pwm_to_port2_bit5_o       <= ctl1.pwm_sel;
         serial_to_port2_bit0_o    <= ctl1.serial_tx_sel;
         timer2_ext_reset_en_o     <= ctl0.t2_ext_rst_en;
         timer2_reset_from_fast0_o <= ctl0.t2_rst_fast0;
         timer2_clock_from_fast1_o <= ctl0.t2_clk_fast1;
         ext_from_analog_o         <= ctl1.ext_from_analog;
      end
   end

   // -----------------------------------------------
   // Event status
   // -----------------------------------------------
   // Expiry and overflow bits are sticky until read; fifo bits follow levels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         event_status <= '0;
      else if (rd_hit && hit(adr_i, `OFS_IO_EVENT_STATUS))
         event_status <= {holding_loaded_i, fifo_full_i,
                          timer1_overflow_i, timer2_overflow_i, soft_timer_expired_i};
      else
         event_status <= {holding_loaded_i, fifo_full_i, event_status[5:0]
                          | {timer1_overflow_i, timer2_overflow_i, soft_timer_expired_i}};
   end

   // -----------------------------------------------
   // Interrupt sources and pending
   // -----------------------------------------------
   assign ext_level = ctl1.ext_from_analog ? analog_channel_seven_i : external_interrupt_pin_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ext_prev <= 1'b0;
      else
         ext_prev <= ext_level;
   end

   always_comb
   begin
      next_raise    = '0;
      next_raise[0] = (timer1_overflow_i && ctl1.t1_ovf_int_en)
                    || (timer2_overflow_i && ctl1.t2_ovf_int_en);
      next_raise[1] = convert_done_i;
      next_raise[2] = ctl1.fast_cond_full ? fifo_full_i : holding_loaded_i;
      next_raise[3] = fast_out_event_i;
      next_raise[4] = fast_line0_event_i;
      next_raise[5] = software_timer_event_i;
      next_raise[6] = serial_event_i;
      next_raise[7] = ext_level && !ext_prev;
   end

   // Set wins over the take of the same source
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pending <= '0;
      else if (vector_take_i && pick.valid)
         pending <= (pending & ~(8'h01 << pick.level)) | next_raise;
      else
         pending <= pending | next_raise;
   end

   // -----------------------------------------------
   // Status word
   // -----------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         processor_status_word <= `PSW_RESET;
      else if (wr_hit && hit(adr_i, `OFS_STATUS_WORD))
         processor_status_word <= dat_i[15:0] & `PSW_WRITE_MASK;
      else
      begin
         if (alu_flags_we_i)
         begin
            processor_status_word[`PSW_ZERO_BIT]  <= alu_flags_i[4];
            processor_status_word[`PSW_NEG_BIT]   <= alu_flags_i[3];
            processor_status_word[`PSW_OVF_BIT]   <= alu_flags_i[2];
            processor_status_word[`PSW_TRAP_BIT]  <= alu_flags_i[1];
            processor_status_word[`PSW_CARRY_BIT] <= alu_flags_i[0];
         end
         if (sticky_we_i)
            processor_status_word[`PSW_STICKY_BIT] <= sticky_i;
      end
   end

   // -----------------------------------------------
   // Vectoring
   // -----------------------------------------------
   // Software must set enable and mask first
   assign eligible = pending & processor_status_word[7:0] & {8{processor_status_word[`PSW_GLOBAL_BIT]}};

   irq_priority_pick #(
      .SOURCES (SOURCES)
   ) u_pick (
      .request_i (eligible),
      .pick_o    (pick)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_request_o    <= 1'b0;
         vector_address_o <= '0;
         vector_level_o   <= '0;
      end
      else
      begin
         irq_request_o    <= pick.valid && !vector_take_i;
         vector_address_o <= pick.address;
         vector_level_o   <= pick.level;
      end
   end

   // -----------------------------------------------
   // Checks
   // -----------------------------------------------
   property p_no_req_when_disabled;
      @(posedge clk_i) disable iff (rst_i)
      !processor_status_word[`PSW_GLOBAL_BIT] |=> !irq_request_o;
   endproperty
   a_no_req_when_disabled: assert property (p_no_req_when_disabled) else $error("Request while disabled");

   property p_top_priority;
      @(posedge clk_i) disable iff (rst_i)
      eligible[7] |=> vector_address_o == 16'h200e;
   endproperty
   a_top_priority: assert property (p_top_priority) else $error("Priority 7 not chosen");

   property p_lowest_vector;
      @(posedge clk_i) disable iff (rst_i)
      (eligible == 8'h01) |=> (vector_address_o == 16'h2000 && vector_level_o == 3'h0);
   endproperty
   a_lowest_vector: assert property (p_lowest_vector) else $error("Overflow vector wrong");

   property p_line0_vector;
      @(posedge clk_i) disable iff (rst_i)
      (eligible[7:4] == 4'h1) |=> vector_address_o == 16'h2008;
   endproperty
   a_line0_vector: assert property (p_line0_vector) else $error("Line 0 vector wrong");

   property p_take_clears;
      @(posedge clk_i) disable iff (rst_i)
      (vector_take_i && pick.valid && !next_raise[pick.level]) |=> !pending[$past(pick.level)];
   endproperty
   a_take_clears: assert property (p_take_clears) else $error("Pending not cleared");

   property p_timer_sticky;
      @(posedge clk_i) disable iff (rst_i)
      soft_timer_expired_i[0] |=> event_status[0];
   endproperty
   a_timer_sticky: assert property (p_timer_sticky) else $error("Timer flag missed");

   property p_overflow_flags;
      @(posedge clk_i) disable iff (rst_i)
      (timer2_overflow_i && timer1_overflow_i) |=> event_status[5:4] == 2'b11;
   endproperty
   a_overflow_flags: assert property (p_overflow_flags) else $error("Overflow flags missed");

   property p_fifo_level;
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (event_status[7] == $past(holding_loaded_i)) && (event_status[6] == $past(fifo_full_i));
   endproperty
   a_fifo_level: assert property (p_fifo_level) else $error("Fifo flags wrong");

   property p_ovf_suppressed;
      @(posedge clk_i) disable iff (rst_i)
      (!ctl1.t1_ovf_int_en && !ctl1.t2_ovf_int_en) |-> !next_raise[0];
   endproperty
   a_ovf_suppressed: assert property (p_ovf_suppressed) else $error("Overflow not gated");

   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("Ack held too long");

   c_request: cover property (@(posedge clk_i) disable iff (rst_i) irq_request_o);
   c_take: cover property (@(posedge clk_i) disable iff (rst_i) vector_take_i && pick.valid);
   c_top: cover property (@(posedge clk_i) disable iff (rst_i) eligible[7] && eligible[0]);
endmodule : irq_event_ctrl

// ### core_model.sv
`timescale 1ns/1ps
module core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        take_en_i,
   input  wire logic        slow_i,
   input  wire logic        irq_request_i,
   input  wire logic [15:0] vector_address_i,
   input  wire logic [2:0]  vector_level_i,
   output logic             vector_take_o
);
   logic [18:0] taken_q[$];
   logic [2:0]  gap;

   // ----------------------------------------
   // Vector fetch
   // ----------------------------------------
   // Gap outlasts the pick latency so a stale request is never taken twice
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vector_take_o <= 1'b0;
         gap <= 3'd0;
      end
      else
      begin
         vector_take_o <= 1'b0;
         if (gap != 3'd0)
            gap <= gap - 3'd1;
         else if (take_en_i && irq_request_i === 1'b1)
         begin
            vector_take_o <= 1'b1;
            taken_q.push_back({vector_level_i, vector_address_i});
            gap <= slow_i ? 3'd7 : 3'd3;
         end
      end
   end
endmodule : core_model

// ### interrupt_and_io_event_control_tb.sv
`timescale 1ns/1ps
module interrupt_and_io_event_control_tb;
   logic        clk_i, rst_i, cyc, stb, we, take_en, slow, fwe, st, swe;
   logic [7:0]  adr;
   logic [3:0]  sel, lv, fast_in_en;
   logic [31:0] dat_w, dat_r;
   logic [10:0] ev;
   logic [4:0]  flags;
   logic        ack, irq_request, vtake, pwm_sel, tx_sel, t2_rst, t2_ext, t2_rf0, t2_cf1, ext_an;
   logic [15:0] vaddr;
   logic [2:0]  vlvl;
   logic [1:0]  fast_out_en;
   int          fail_count, num_checks, cycles, t2r_count;

   irq_event_ctrl #(.SOURCES(8)) irq_event_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .soft_timer_expired_i(ev[10:7]), .timer1_overflow_i(ev[6]), .timer2_overflow_i(ev[5]),
      .fifo_full_i(lv[2]), .holding_loaded_i(lv[3]), .convert_done_i(ev[4]), .fast_out_event_i(ev[3]),
      .fast_line0_event_i(ev[2]), .software_timer_event_i(ev[1]), .serial_event_i(ev[0]),
      .external_interrupt_pin_i(lv[1]), .analog_channel_seven_i(lv[0]), .alu_flags_i(flags),
      .alu_flags_we_i(fwe), .sticky_i(st), .sticky_we_i(swe), .vector_take_i(vtake),
      .irq_request_o(irq_request), .vector_address_o(vaddr), .vector_level_o(vlvl),
      .fast_input_enable_o(fast_in_en), .fast_output_enable_o(fast_out_en), .pwm_to_port2_bit5_o(pwm_sel),
      .serial_to_port2_bit0_o(tx_sel), .timer2_reset_o(t2_rst), .timer2_ext_reset_en_o(t2_ext),
      .timer2_reset_from_fast0_o(t2_rf0), .timer2_clock_from_fast1_o(t2_cf1), .ext_from_analog_o(ext_an));

   core_model core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .take_en_i(take_en), .slow_i(slow),
      .irq_request_i(irq_request), .vector_address_i(vaddr), .vector_level_i(vlvl), .vector_take_o(vtake));

   // ----------------------------------------
   // Clock, watchdog, helpers
   // ----------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (t2_rst === 1'b1)
         t2r_count++;
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end

   task conclude;
   begin
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask : conclude

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask : check

   // Holds the request until ack is sampled; the next call idles one edge first
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
   begin
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hf;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("ack", 32'(ack), 32'h1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   end
   endtask : wb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
   begin
      wb(1'b1, a, d, q);
      repeat (2) @(posedge clk_i);
   end
   endtask : wr

   task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
   begin
      wb(1'b0, a, 32'h0, q);
      check(name, q, exp);
   end
   endtask : rd_chk

   task pulse(input logic [10:0] v);
   begin
      @(posedge clk_i);
      ev <= v;
      @(posedge clk_i);
      ev <= '0;
   end
   endtask : pulse

   task set_lv(input logic [3:0] v);
   begin
      @(posedge clk_i);
      lv <= v;
   end
   endtask : set_lv

   // Negative level means no vector may be taken in the window
   task take(input string name, input int lvl);
      int n;
      logic [18:0] e;
   begin
      n = 0;
      while (core_model_inst.taken_q.size() == 0 && n < 30)
      begin
         @(posedge clk_i);
         n++;
      end
      if (lvl < 0)
         check(name, 32'(core_model_inst.taken_q.size()), 32'h0);
      else
      begin
         e = (core_model_inst.taken_q.size() > 0) ? core_model_inst.taken_q.pop_front() : 'x;
         check(name, 32'(e), 32'({lvl[2:0], 16'h2000 + 16'(2 * lvl)}));
      end
   end
   endtask : take

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_ctl_zero;
      logic [7:0] p;
      int c0;
   begin
      for (int i = 0; i < 2; i++)
      begin
         p = i ? 8'haa : 8'h55;
         c0 = t2r_count;
         wr(8'h54, {24'h0, p});
         check("fast_in_en", 32'(fast_in_en), 32'({p[6], p[4], p[2], p[0]}));
         check("t2_ctl", 32'({t2_ext, t2_rf0, t2_cf1}), 32'({p[3], p[5], p[7]}));
         check("t2_reset_pulses", t2r_count - c0, 32'(p[1]));
         rd_chk("ctl_zero_read", 8'h54, 32'h0);
      end
   end
   endtask : t_ctl_zero

   task t_ctl_one;
      logic [7:0] p;
   begin
      for (int i = 0; i < 2; i++)
      begin
         p = i ? 8'haa : 8'h55;
         wr(8'h58, {24'h0, p});
         check("ctl_one", 32'({fast_out_en, pwm_sel, tx_sel, ext_an}), 32'({p[6], p[4], p[0], p[5], p[1]}));
      end
      wr(8'h58, 32'h0);
   end
   endtask : t_ctl_one

   task t_status;
   begin
      set_lv(4'hc);
      pulse(11'b0101_1_1_00000);
      repeat (2) @(posedge clk_i);
      rd_chk("status", 8'h58, 32'hf5);
      rd_chk("status_reread", 8'h58, 32'hc0);
      set_lv(4'h0);
      repeat (2) @(posedge clk_i);
      rd_chk("status_idle", 8'h58, 32'h0);
      rd_chk("pending", 8'h64, 32'h04);
      check("no_request", 32'(irq_request), 32'h0);
   end
   endtask : t_status

   task t_psw;
   begin
      wr(8'h60, 32'hffff);
      rd_chk("psw_all", 8'h60, 32'hfbff);
      @(posedge clk_i);
      flags <= 5'b01001;
      fwe <= 1'b1;
      st <= 1'b0;
      swe <= 1'b1;
      @(posedge clk_i);
      fwe <= 1'b0;
      swe <= 1'b0;
      rd_chk("psw_flags_a", 8'h60, 32'h4aff);
      wr(8'h60, 32'h0);
      @(posedge clk_i);
      flags <= 5'b10110;
      fwe <= 1'b1;
      st <= 1'b1;
      swe <= 1'b1;
      @(posedge clk_i);
      fwe <= 1'b0;
      swe <= 1'b0;
      rd_chk("psw_flags_b", 8'h60, 32'hb100);
      wr(8'h60, 32'h0);
   end
   endtask : t_psw

   task t_order;
   begin
      take_en <= 1'b1;
      pulse(11'h01f);
      take("disabled", -1);
      rd_chk("pending_all", 8'h64, 32'h7e);
      wr(8'h60, 32'h02ff);
      for (int l = 6; l >= 1; l--)
      begin
         slow <= l[0];
         take("order", l);
      end
   end
   endtask : t_order

   task t_ext;
   begin
      wr(8'h58, 32'h02);
      set_lv(4'h2);
      take("ext_pin_unsel", -1);
      set_lv(4'h3);
      take("ext_analog", 7);
      set_lv(4'h0);
      wr(8'h58, 32'h0);
      set_lv(4'h1);
      take("analog_unsel", -1);
      set_lv(4'h3);
      take("ext_pin", 7);
      set_lv(4'h0);
   end
   endtask : t_ext

   task t_ovf;
   begin
      for (int i = 0; i < 2; i++)
      begin
         wr(8'h58, i ? 32'h08 : 32'h04);
         pulse(i ? 11'h040 : 11'h020);
         take("ovf_off", -1);
         pulse(i ? 11'h020 : 11'h040);
         take("ovf_on", 0);
      end
   end
   endtask : t_ovf

   task t_mask;
   begin
      wr(8'h60, 32'h02fd);
      pulse(11'h010);
      take("masked", -1);
      rd_chk("pending_masked", 8'h64, 32'h02);
      take_en <= 1'b0;
      wr(8'h60, 32'h02ff);
      rd_chk("vector", 8'h68, 32'h92002);
      check("request", 32'(irq_request), 32'h1);
      take_en <= 1'b1;
      take("unmasked", 1);
   end
   endtask : t_mask

   task t_fifo;
   begin
      wr(8'h58, 32'h80);
      set_lv(4'h8);
      set_lv(4'h0);
      take("holding_unsel", -1);
      set_lv(4'h4);
      set_lv(4'h0);
      take("fifo_full", 2);
   end
   endtask : t_fifo

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_i, cyc, stb, we, take_en, slow, fwe, st, swe} = 9'b1_0000_0000;
      {adr, sel, lv, dat_w, ev, flags} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("reset_outs", 32'({irq_request, fast_in_en, fast_out_en, pwm_sel, tx_sel, t2_ext}), 32'h0);
      t_ctl_zero();
      t_ctl_one();
      t_status();
      t_psw();
      t_order();
      t_ext();
      t_ovf();
      t_mask();
      t_fifo();
      wr(8'h70, 32'hffffffff);
      rd_chk("unmapped", 8'h70, 32'h0);
      conclude();
   end
endmodule : interrupt_and_io_event_control_tb
